// *** core/frs_pkg.sv ***
package frs_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_MODE_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CTRL_ONE = 12'h004;
    localparam logic [11:0] ADDR_MODE_SEL = 12'h008;
    localparam logic [11:0] ADDR_CMD = 12'h00C;
    localparam logic [11:0] ADDR_CMD_ADDR = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;
    localparam logic [11:0] ADDR_READ_DATA = 12'h018;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int READY_POS = 0;
    localparam int REWRITE_EN_POS = 1;
    localparam int PRG_ERR_POS = 6;
    localparam int ERS_ERR_POS = 7;
    localparam int ARRAY_MODE_POS = 8;
    localparam int BUSY_POS = 9;
    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_UNLOCK = 8'h82;
    localparam logic [7:0] CTRL_LOCK = 8'h80;
    localparam logic [7:0] RAM_EXEC_MODE = 8'h02;
    localparam logic [7:0] MODE_SEL_RESET = 8'h00;
    localparam logic [15:0] ERASE_CODE = 16'h0020;
    localparam logic [15:0] ERASE_CONFIRM_CODE = 16'h00D0;
    localparam logic [15:0] PROGRAM_CODE = 16'h0041;
    localparam logic [15:0] CLEAR_STATUS_CODE = 16'h0050;
    localparam logic [15:0] READ_ARRAY_CODE = 16'h00FF;
    localparam int RECORD_BYTES = 256;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int ERASE_TIME_US = 100;
    localparam int PROGRAM_TIME_US = 20;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 16;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FRS_IDLE = 3'b000,
        FRS_ERASE_WAIT = 3'b001,
        FRS_PROG_D1 = 3'b010,
        FRS_PROG_D2 = 3'b011,
        FRS_BUSY = 3'b100
    } frs_state_t;
endpackage

// *** core/frs_timer.sv ***
`timescale 1ns/1ns
module frs_timer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic [frs_pkg::TIMER_W-1:0] load,
    output logic done
);
    typedef struct packed {
        logic [frs_pkg::TIMER_W-1:0] count;
        logic run;
        logic done;
    } frs_tmr_t;
    frs_tmr_t st;
    frs_tmr_t next_st;
    // ------------------------------------------------------------
    // Countdown, one-cycle done pulse
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (start) begin
            next_st.count = load;
            next_st.run = 1'b1;
        end else if (st.run) begin
            if (st.count <= 16'h0001) begin
                next_st.run = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.count = st.count - 16'h0001;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign done = st.done;
endmodule // frs_timer

// *** core/frs_sequencer.sv ***
`timescale 1ns/1ns
// Operation
// - 0x82 unlocks mode select, 0x02 chooses mode
// - 0x80 locks mode select
// - Erase: 0020h then 00D0h, same address
// - Program: 0041h then two data words
// - Error bits encode sequence, erase, program
// - Read array restores normal reads
module frs_sequencer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_fail,
    output logic flash_we,
    output logic [23:0] flash_addr,
    output logic [31:0] flash_data,
    output logic flash_erase,
    output logic array_read_mode
);
    typedef struct packed {
        frs_pkg::frs_state_t state;
        logic armed;
        logic rewrite_enable_bit;
        logic mode_unlocked;
        logic [7:0] flash_control_reg_one;
        logic [7:0] rewrite_mode_select_reg;
        logic [23:0] cmd_addr;
        logic [23:0] op_addr;
        logic [15:0] data_lo;
        logic flash_ready_flag;
        logic erase_error_bit;
        logic program_error_bit;
        logic is_erase;
        logic array_mode;
        logic flash_we;
        logic flash_erase;
        logic [31:0] flash_data;
        logic [31:0] prdata;
    } frs_st_t;
    frs_st_t st;
    frs_st_t next_st;
    logic wr;
    logic rd;
    logic mapped;
    logic tmr_start;
    logic tmr_done;
    logic [frs_pkg::TIMER_W-1:0] tmr_load;
    logic [15:0] cmd;
    logic cmd_ok;
    // ------------------------------------------------------------
    // Bus strobes; reads latch in setup so prdata stands in access
    // ------------------------------------------------------------
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign cmd = pwdata[15:0];
    assign cmd_ok = st.rewrite_enable_bit
        && st.rewrite_mode_select_reg == frs_pkg::RAM_EXEC_MODE;
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        case (paddr)
            frs_pkg::ADDR_MODE_CTRL, frs_pkg::ADDR_CTRL_ONE,
            frs_pkg::ADDR_MODE_SEL, frs_pkg::ADDR_CMD,
            frs_pkg::ADDR_CMD_ADDR, frs_pkg::ADDR_STATUS,
            frs_pkg::ADDR_READ_DATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    frs_timer u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(tmr_start),
        .load(tmr_load),
        .done(tmr_done)
    );
    // ------------------------------------------------------------
    // Register writes, command decode and sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.flash_we = 1'b0;
        next_st.flash_erase = 1'b0;
        tmr_start = 1'b0;
        tmr_load = '0;
        if (wr && paddr == frs_pkg::ADDR_MODE_CTRL) begin
            if (!pwdata[frs_pkg::REWRITE_EN_POS]) begin
                next_st.rewrite_enable_bit = 1'b0;
                next_st.armed = 1'b1;
            end else if (st.armed) begin
                next_st.rewrite_enable_bit = 1'b1;
                next_st.armed = 1'b0;
            end
        end
        if (wr && paddr == frs_pkg::ADDR_CTRL_ONE) begin
            next_st.flash_control_reg_one = pwdata[7:0];
            if (pwdata[7:0] == frs_pkg::CTRL_UNLOCK) begin
                next_st.mode_unlocked = 1'b1;
            end else if (pwdata[7:0] == frs_pkg::CTRL_LOCK) begin
                next_st.mode_unlocked = 1'b0;
            end
        end
        if (wr && paddr == frs_pkg::ADDR_MODE_SEL && st.mode_unlocked) begin
            next_st.rewrite_mode_select_reg = pwdata[7:0];
        end
        if (wr && paddr == frs_pkg::ADDR_CMD_ADDR) begin
            next_st.cmd_addr = pwdata[23:0];
        end
        if (wr && paddr == frs_pkg::ADDR_CMD && cmd_ok) begin
            case (st.state)
                frs_pkg::FRS_IDLE: begin
                    if (cmd == frs_pkg::ERASE_CODE) begin
                        next_st.op_addr = st.cmd_addr;
                        next_st.array_mode = 1'b0;
                        next_st.state = frs_pkg::FRS_ERASE_WAIT;
                    end else if (cmd == frs_pkg::PROGRAM_CODE) begin
                        next_st.op_addr = st.cmd_addr;
                        next_st.array_mode = 1'b0;
                        next_st.state = frs_pkg::FRS_PROG_D1;
                    end else if (cmd == frs_pkg::CLEAR_STATUS_CODE) begin
                        next_st.erase_error_bit = 1'b0;
                        next_st.program_error_bit = 1'b0;
                    end else if (cmd == frs_pkg::READ_ARRAY_CODE) begin
                        next_st.array_mode = 1'b1;
                    end
                end
                frs_pkg::FRS_ERASE_WAIT: begin
                    if (cmd == frs_pkg::ERASE_CONFIRM_CODE
                        && st.cmd_addr == st.op_addr) begin
                        next_st.flash_ready_flag = 1'b0;
                        next_st.is_erase = 1'b1;
                        next_st.flash_erase = 1'b1;
                        tmr_start = 1'b1;
                        tmr_load = frs_pkg::TIMER_W'(frs_pkg::ERASE_CYCLES);
                        next_st.state = frs_pkg::FRS_BUSY;
                    end else begin
                        next_st.erase_error_bit = 1'b1;
                        next_st.program_error_bit = 1'b1;
                        next_st.state = frs_pkg::FRS_IDLE;
                    end
                end
                frs_pkg::FRS_PROG_D1: begin
                    next_st.data_lo = cmd;
                    next_st.state = frs_pkg::FRS_PROG_D2;
                end
                frs_pkg::FRS_PROG_D2: begin
                    next_st.flash_data = {cmd, st.data_lo};
                    next_st.flash_we = 1'b1;
                    next_st.flash_ready_flag = 1'b0;
                    next_st.is_erase = 1'b0;
                    tmr_start = 1'b1;
                    tmr_load = frs_pkg::TIMER_W'(frs_pkg::PROGRAM_CYCLES);
                    next_st.state = frs_pkg::FRS_BUSY;
                end
                frs_pkg::FRS_BUSY: begin
                end
                default: next_st.state = frs_pkg::FRS_IDLE;
            endcase
        end
        if (st.state == frs_pkg::FRS_BUSY && tmr_done) begin
            next_st.flash_ready_flag = 1'b1;
            next_st.state = frs_pkg::FRS_IDLE;
            if (op_fail && st.is_erase) begin
                next_st.erase_error_bit = 1'b1;
            end else if (op_fail) begin
                next_st.program_error_bit = 1'b1;
            end
        end
        if (rd) begin
            case (paddr)
                frs_pkg::ADDR_MODE_CTRL: next_st.prdata = {30'h0,
                    st.rewrite_enable_bit, st.flash_ready_flag};
                frs_pkg::ADDR_CTRL_ONE:
                    next_st.prdata = {24'h0, st.flash_control_reg_one};
                frs_pkg::ADDR_MODE_SEL:
                    next_st.prdata = {24'h0, st.rewrite_mode_select_reg};
                frs_pkg::ADDR_CMD_ADDR: next_st.prdata = {8'h0, st.cmd_addr};
                frs_pkg::ADDR_STATUS: next_st.prdata = {22'h0,
                    st.state == frs_pkg::FRS_BUSY, st.array_mode,
                    st.erase_error_bit, st.program_error_bit, 4'h0,
                    st.rewrite_enable_bit, st.flash_ready_flag};
                frs_pkg::ADDR_READ_DATA: next_st.prdata = st.flash_data;
                default: next_st.prdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
            st.state <= frs_pkg::FRS_IDLE;
            st.flash_ready_flag <= 1'b1;
            st.array_mode <= 1'b1;
            st.rewrite_mode_select_reg <= frs_pkg::MODE_SEL_RESET;
        end else begin
            st <= next_st;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = st.prdata;
    assign flash_we = st.flash_we;
    assign flash_erase = st.flash_erase;
    assign flash_addr = st.op_addr;
    assign flash_data = st.flash_data;
    assign array_read_mode = st.array_mode;
endmodule // frs_sequencer

// *** test/frs_monitor.sv ***
`timescale 1ns/1ns
// ------------------------------
// Port checker
// ------------------------------
module frs_monitor (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic flash_we,
    input wire logic flash_erase,
    input wire logic array_read_mode
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic acc, cmdw, cnf, rda;
    assign acc = psel && penable;
    assign cmdw = acc && pwrite && paddr == frs_pkg::ADDR_CMD;
    assign cnf = cmdw && pwdata[15:0] == frs_pkg::ERASE_CONFIRM_CODE;
    assign rda = cmdw && pwdata[15:0] == frs_pkg::READ_ARRAY_CODE;
    property p_ers; flash_erase |-> $past(cnf) || $past(cnf, 2); endproperty
    a_ers: assert property (p_ers) else $error("erase w/o confirm");
    property p_prg; flash_we |-> $past(cmdw) || $past(cmdw, 2); endproperty
    a_prg: assert property (p_prg) else $error("program w/o data");
    property p_ep; flash_erase |=> !flash_erase [*2]; endproperty
    a_ep: assert property (p_ep) else $error("erase pulse long");
    property p_wp; flash_we |=> !flash_we; endproperty
    a_wp: assert property (p_wp) else $error("program pulse long");
    property p_ex; !(flash_we && flash_erase); endproperty
    a_ex: assert property (p_ex) else $error("erase with program");
    property p_off; flash_erase || flash_we |-> ##[0:1] !array_read_mode;
    endproperty
    a_off: assert property (p_off) else $error("array mode kept");
    property p_on; rda |-> ##[1:2] array_read_mode; endproperty
    a_on: assert property (p_on) else $error("read array lost");
    property p_err; pslverr |-> acc; endproperty
    a_err: assert property (p_err) else $error("error outside access");
    property p_um; acc && paddr > frs_pkg::ADDR_READ_DATA |-> pslverr;
    endproperty
    a_um: assert property (p_um) else $error("unmapped not refused");
    property p_rs; $fell(rst) |-> array_read_mode && !flash_erase;
    endproperty
    a_rs: assert property (p_rs) else $error("reset state wrong");
    cover property (flash_erase);
    cover property (flash_we);
    cover property (pslverr);
endmodule // frs_monitor
bind frs_sequencer frs_monitor i_frs_monitor (.clk_sys, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pslverr, .flash_we, .flash_erase,
    .array_read_mode);

// *** test/frs_flash_model.sv ***
`timescale 1ns/1ns
// ------------------------------
// Flash array model
// ------------------------------
module frs_flash_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic flash_we,
    input wire logic flash_erase,
    input wire logic [23:0] flash_addr,
    input wire logic [31:0] flash_data,
    input wire logic fail_arm,
    output logic op_fail,
    output int n_ops,
    output logic [23:0] last_addr,
    output logic [31:0] last_data
);
    assign op_fail = fail_arm;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            n_ops <= 0;
            last_addr <= 24'h0;
            last_data <= 32'h0;
        end else if (flash_we || flash_erase) begin
            n_ops <= n_ops + 1;
            last_addr <= flash_addr;
            last_data <= flash_we ? flash_data : 32'hFFFFFFFF;
        end
    end
endmodule // frs_flash_model

// *** test/tb_flash_rewrite_sequencer.sv ***
`timescale 1ns/1ns
module tb_flash_rewrite_sequencer;
    localparam logic [11:0] MC = frs_pkg::ADDR_MODE_CTRL;
    localparam logic [11:0] ST = frs_pkg::ADDR_STATUS;
    localparam logic [11:0] MS = frs_pkg::ADDR_MODE_SEL;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, op_fail;
    logic flash_we, flash_erase, array_read_mode, fail_arm, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, flash_data, rd, last_data;
    logic [23:0] flash_addr, last_addr;
    int n_fail, cmp_count, n_ops, k;
    frs_sequencer i_frs_sequencer (.clk_sys, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .op_fail,
        .flash_we, .flash_addr, .flash_data, .flash_erase, .array_read_mode);
    frs_flash_model i_frs_flash_model (.clk_sys, .rst, .flash_we,
        .flash_erase, .flash_addr, .flash_data, .fail_arm, .op_fail, .n_ops,
        .last_addr, .last_data);
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end
    // ------------------------------
    // Bench tasks
    // ------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        n = 0;
        @(posedge clk_sys);
        while (pready !== 1'h1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (pready !== 1'h1) begin
            n_fail++;
        end
        err = pslverr;
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task cmd(input logic [15:0] c);
        wr(frs_pkg::ADDR_CMD, {16'h0, c});
    endtask
    task wait_ready;
        k = 0;
        do begin
            xfer(1'h0, ST, 32'h0);
            k++;
        end while (rd[0] !== 1'h1 && k < 2000);
        if (rd[0] !== 1'h1) begin
            n_fail++;
        end
    endtask
    // ------------------------------
    // Tests
    // ------------------------------
    initial begin
        rst = 1'h1;
        {psel, penable, pwrite, fail_arm} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'h0;
        rchk(ST, 32'h101);
        chk(array_read_mode, 32'h1);
        rchk(MS, 32'h0);
        wr(12'h020, 32'h1);
        chk(err, 32'h1);
        rchk(12'h020, 32'h0);
        wr(MC, 32'h2);
        rchk(MC, 32'h1);
        wr(MC, 32'h0);
        wr(MC, 32'h2);
        rchk(MC, 32'h3);
        wr(MS, 32'h2);
        rchk(MS, 32'h0);
        wr(frs_pkg::ADDR_CTRL_ONE, 32'h82);
        wr(MS, 32'h2);
        rchk(MS, 32'h2);
        wr(frs_pkg::ADDR_CTRL_ONE, 32'h80);
        wr(MS, 32'h0);
        rchk(MS, 32'h2);
        wr(frs_pkg::ADDR_CMD_ADDR, 32'hFFFE);
        cmd(16'h0020);
        cmd(16'h00D0);
        rchk(ST, 32'h202);
        chk(last_addr, 24'hFFFE);
        chk(array_read_mode, 32'h0);
        wait_ready;
        chk(rd, 32'h3);
        @(posedge clk_sys) fail_arm <= 1'h1;
        cmd(16'h0020);
        cmd(16'h00D0);
        wait_ready;
        chk(rd, 32'h83);
        @(posedge clk_sys) fail_arm <= 1'h0;
        cmd(16'h0050);
        rchk(ST, 32'h3);
        cmd(16'h0020);
        cmd(16'h0041);
        rchk(ST, 32'hC3);
        cmd(16'h0050);
        rchk(ST, 32'h3);
        cmd(16'h0041);
        cmd(16'h1234);
        cmd(16'hABCD);
        rchk(ST, 32'h202);
        wait_ready;
        chk(last_data, 32'hABCD1234);
        rchk(frs_pkg::ADDR_READ_DATA, 32'hABCD1234);
        @(posedge clk_sys) fail_arm <= 1'h1;
        cmd(16'h0041);
        cmd(16'h5555);
        cmd(16'hAAAA);
        wait_ready;
        chk(rd, 32'h43);
        @(posedge clk_sys) fail_arm <= 1'h0;
        cmd(16'h00FF);
        rchk(ST, 32'h143);
        chk(array_read_mode, 32'h1);
        cmd(16'h0050);
        rchk(ST, 32'h103);
        wr(MC, 32'h0);
        cmd(16'h0020);
        cmd(16'h00D0);
        rchk(ST, 32'h101);
        chk(n_ops, 32'h4);
        report_and_stop;
    end
    initial begin
        #(40 * 60000);
        n_fail++;
        report_and_stop;
    end
endmodule // tb_flash_rewrite_sequencer
